// ---- rtl/ibt_pkg.sv ----
// ibt_pkg: constants and carrier types for the indirect branch target checker.
// assumes one 200 MHz clock, an AXI4-Lite register master and a byte-wide
// memory read port for the legacy page map.
//
// Overview of operation
// - indirect branch without no-track prefix arms the tracker
// - breakpoint keeps waiting state, trap wins
// - enclave breakpoint: opt-out opcode fault, opt-in breakpoint trap
// - legacy treatment needs enable, non-marker, legacy page
// - missing marker without legacy enable faults
// - map byte at base plus address bits 15 and up
// - test bit 14:12, fault or idle plus tracker_suppressed_flag
// - legacy pass restarts target without event window
// - one map bit per 4K page, 1 legacy
// - index bits 31:12 or 47:12 in 64-bit mode
// - lookup fault delivered, tracker keeps waiting
// - suppressed tracker ignores indirect branches
// - marker after suppression clears it if enabled
// - transaction abort handler needs no marker
// - tracking works in transactions, abort resets tracker
// - missing-marker fault beats device-unavailable and opcode
// - debug traps and code breakpoints precede marker fault
// - return from debug handler rearms tracker
// - waiting without marker limits speculation
// - sequential speculation after branch also limited
package ibt_pkg;
    // register byte offsets
    localparam logic [7:0] REG_USER_CTL = 8'h00;
    localparam logic [7:0] REG_SUPV_CTL = 8'h04;
    localparam logic [7:0] REG_MAP_BASE_LO = 8'h08;
    localparam logic [7:0] REG_MAP_BASE_HI = 8'h0C;
    localparam logic [7:0] REG_ENCL_BASE_LO = 8'h10;
    localparam logic [7:0] REG_ENCL_BASE_HI = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    // control register fields
    localparam int CTL_TRACK_EN = 0;
    localparam int CTL_LEG_EN = 1;
    localparam int CTL_SUPP_DIS = 2;
    localparam int CTL_TRACKER = 3;
    localparam int CTL_SUPPRESSED = 4;
    localparam logic [4:0] CTL_RESET = 5'h00;
    // address field positions
    localparam int PAGE_LSB = 12;
    localparam int BYTE_LSB = 15;
    localparam int LEG_MSB = 31;
    localparam int LONG_MSB = 47;
    localparam int USER_PL = 3;
    // speculation budget in waiting state
    localparam logic [3:0] SPEC_MAX_INSTR = 4'h7;
    localparam logic [3:0] SPEC_MAX_LOADS = 4'h5;
    // events delivered, priority encoded later
    typedef enum logic [3:0] {
        IBT_EV_NONE, IBT_EV_DBG_TRAP, IBT_EV_CODE_BP, IBT_EV_BP, IBT_EV_CP,
        IBT_EV_NM, IBT_EV_UD, IBT_EV_GD, IBT_EV_LOOKUP_FAULT
    } ibt_event_t;
    typedef enum logic [1:0] {IBT_ST_RUN, IBT_ST_LOOKUP, IBT_ST_WAIT_MEM} ibt_state_t;
    // one retiring instruction as seen by decode
    typedef struct packed {
        logic valid;
        logic [1:0] pl;
        logic is_indirect;
        logic no_track_prefix;
        logic is_marker;
        logic is_bp1;
        logic is_interrupt_return_instr_dbg;
        logic is_transaction_begin_instr_abort;
        logic enclave;
        logic enclave_opt_in;
        logic long_mode_active;
        logic cs_64;
        logic dbg_trap;
        logic code_bp;
        logic nm;
        logic ud;
        logic gd;
        logic [47:0] linear_instruction_pointer;
    } ibt_instr_t;
    // per privilege class control
    typedef struct packed {
        logic suppressed;
        logic tracker_wait;
        logic supp_dis;
        logic leg_en;
        logic track_en;
    } ibt_ctl_t;
endpackage

// ---- rtl/ibt_check.sv ----
// ibt_check: indirect branch landing marker tracker, legacy page map lookup
// and fault priority for the retire path.
// assumes the retire stage holds an instruction until ins_ready, and the map
// memory answers one byte per request with an optional fault flag.
`timescale 1ns/1ps
module ibt_check (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // retire stream
    input wire ibt_pkg::ibt_instr_t ins,
    output logic ins_ready,
    output ibt_pkg::ibt_event_t ev_code,
    output logic ev_valid,
    output logic restart_no_window,
    // speculation gate
    input wire logic spec_issue,
    input wire logic spec_is_load,
    input wire logic next_is_marker,
    output logic spec_stall,
    // legacy map memory read
    output logic [47:0] mem_addr,
    output logic mem_req,
    input wire logic mem_ack,
    input wire logic [7:0] mem_data,
    input wire logic mem_fault,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------
    // state record
    // ------------------------------------------------------------
    typedef struct packed {
        ibt_pkg::ibt_ctl_t user_ctl;
        ibt_pkg::ibt_ctl_t supv_ctl;
        logic [47:0] map_base;
        logic [47:0] encl_base;
        ibt_pkg::ibt_state_t st;
        logic [47:0] la;
        logic wide;
        ibt_pkg::ibt_event_t ev;
        logic ev_v;
        logic restart;
        logic [47:0] mem_addr;
        logic mem_req;
        logic [3:0] spec_cnt;
        logic [3:0] load_cnt;
        logic aw_v;
        logic [7:0] aw_a;
        logic w_v;
        logic [31:0] w_d;
        logic [3:0] w_s;
        logic b_v;
        logic [1:0] b_r;
        logic r_v;
        logic [31:0] r_d;
        logic [1:0] r_r;
    } ibt_state_rec_t;

    ibt_state_rec_t s_reg;
    ibt_state_rec_t s_next;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // byte lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // map byte address: base plus page-group index of the offset address
    function automatic logic [47:0] map_byte_addr(input logic [47:0] base, input logic [47:0] la, input logic wide);
        logic [47:0] idx;
        idx = 48'h0;
        if (wide) begin
            idx = {15'h0000, la[ibt_pkg::LONG_MSB:ibt_pkg::BYTE_LSB]};
        end else begin
            idx = {31'h00000000, la[ibt_pkg::LEG_MSB:ibt_pkg::BYTE_LSB]};
        end
        return base + idx;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        ibt_pkg::ibt_ctl_t c;
        logic user;
        logic armed;
        logic [31:0] rd;
        logic [47:0] la;
        c = s_reg.user_ctl;
        user = 1'b0;
        armed = 1'b0;
        rd = 32'h00000000;
        la = 48'h0;
        s_next = s_reg;
        s_next.ev_v = 1'b0;
        s_next.ev = ibt_pkg::IBT_EV_NONE;
        s_next.restart = 1'b0;
        user = (ins.pl == 2'(ibt_pkg::USER_PL));
        c = user ? s_reg.user_ctl : s_reg.supv_ctl;

        // retire handling
        case (s_reg.st)
            ibt_pkg::IBT_ST_RUN: begin
                if (ins.valid) begin
                    armed = c.track_en && c.tracker_wait;
                    if (ins.dbg_trap) begin
                        s_next.ev = ibt_pkg::IBT_EV_DBG_TRAP;
                    end else if (ins.code_bp) begin
                        s_next.ev = ibt_pkg::IBT_EV_CODE_BP;
                    end else if (ins.is_bp1 && ins.enclave && !ins.enclave_opt_in) begin
                        s_next.ev = ibt_pkg::IBT_EV_UD;
                        if (armed) begin
                            s_next.ev = ibt_pkg::IBT_EV_CP;
                        end
                    end else if (ins.is_bp1) begin
                        s_next.ev = ibt_pkg::IBT_EV_BP;
                    end else if (ins.is_transaction_begin_instr_abort) begin
                        c.tracker_wait = 1'b0;
                        c.suppressed = 1'b0;
                    end else if (armed && !ins.is_marker) begin
                        if (c.leg_en) begin
                            la = ins.linear_instruction_pointer - (ins.enclave ? s_reg.encl_base : 48'h0);
                            s_next.la = la;
                            s_next.wide = ins.long_mode_active && ins.cs_64;
                            s_next.st = ibt_pkg::IBT_ST_LOOKUP;
                        end else begin
                            s_next.ev = ibt_pkg::IBT_EV_CP;
                        end
                    end else if (ins.is_marker) begin
                        if (c.track_en) begin
                            c.tracker_wait = 1'b0;
                            c.suppressed = 1'b0;
                        end
                    end else if (ins.nm) begin
                        s_next.ev = ibt_pkg::IBT_EV_NM;
                    end else if (ins.ud) begin
                        s_next.ev = ibt_pkg::IBT_EV_UD;
                    end else if (ins.gd) begin
                        s_next.ev = ibt_pkg::IBT_EV_GD;
                    end else if (ins.is_interrupt_return_instr_dbg) begin
                        c.tracker_wait = c.track_en && !c.suppressed;
                    end else if (ins.is_indirect && !ins.no_track_prefix && c.track_en && !c.suppressed) begin
                        c.tracker_wait = 1'b1;
                    end
                    // suppressed tracker leaves indirect branches unchecked
                    if (ins.is_indirect && c.suppressed) begin
                        c.tracker_wait = 1'b0;
                    end
                    s_next.ev_v = (s_next.ev != ibt_pkg::IBT_EV_NONE);
                    if (user) begin
                        s_next.user_ctl = c;
                    end else begin
                        s_next.supv_ctl = c;
                    end
                end
            end
            ibt_pkg::IBT_ST_LOOKUP: begin
                s_next.mem_addr = map_byte_addr(s_reg.map_base, s_reg.la, s_reg.wide);
                s_next.mem_req = 1'b1;
                s_next.st = ibt_pkg::IBT_ST_WAIT_MEM;
            end
            ibt_pkg::IBT_ST_WAIT_MEM: begin
                if (mem_ack) begin
                    s_next.mem_req = 1'b0;
                    s_next.st = ibt_pkg::IBT_ST_RUN;
                    s_next.ev_v = 1'b1;
                    if (mem_fault) begin
                        s_next.ev = ibt_pkg::IBT_EV_LOOKUP_FAULT;
                    end else if (!mem_data[s_reg.la[14:ibt_pkg::PAGE_LSB]]) begin
                        s_next.ev = ibt_pkg::IBT_EV_CP;
                    end else begin
                        s_next.ev_v = 1'b0;
                        s_next.restart = 1'b1;
                        c.tracker_wait = 1'b0;
                        c.suppressed = !c.supp_dis;
                        if (user) begin
                            s_next.user_ctl = c;
                        end else begin
                            s_next.supv_ctl = c;
                        end
                    end
                end
            end
            default: begin
                s_next.st = ibt_pkg::IBT_ST_RUN;
            end
        endcase

        // speculation budget while the tracker waits
        if (!(c.tracker_wait && c.track_en) || next_is_marker) begin
            s_next.spec_cnt = 4'h0;
            s_next.load_cnt = 4'h0;
        end else if (spec_issue && !spec_stall) begin
            s_next.spec_cnt = s_reg.spec_cnt + 4'h1;
            if (spec_is_load) begin
                s_next.load_cnt = s_reg.load_cnt + 4'h1;
            end
        end

        // AXI4-Lite write channel capture
        if (s_axi_awvalid && s_axi_awready) begin
            s_next.aw_v = 1'b1;
            s_next.aw_a = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_next.w_v = 1'b1;
            s_next.w_d = s_axi_wdata;
            s_next.w_s = s_axi_wstrb;
        end
        if (s_reg.b_v && s_axi_bready) begin
            s_next.b_v = 1'b0;
        end
        if (s_reg.aw_v && s_reg.w_v && !s_reg.b_v) begin
            s_next.aw_v = 1'b0;
            s_next.w_v = 1'b0;
            s_next.b_v = 1'b1;
            s_next.b_r = 2'h0;
            case (s_reg.aw_a)
                ibt_pkg::REG_USER_CTL: s_next.user_ctl = 5'(merge(32'(s_next.user_ctl), s_reg.w_d, s_reg.w_s));
                ibt_pkg::REG_SUPV_CTL: s_next.supv_ctl = 5'(merge(32'(s_next.supv_ctl), s_reg.w_d, s_reg.w_s));
                ibt_pkg::REG_MAP_BASE_LO: s_next.map_base[31:0] = merge(s_reg.map_base[31:0], s_reg.w_d, s_reg.w_s);
                ibt_pkg::REG_MAP_BASE_HI: s_next.map_base[47:32] =
                    16'(merge({16'h0000, s_reg.map_base[47:32]}, s_reg.w_d, s_reg.w_s));
                ibt_pkg::REG_ENCL_BASE_LO: s_next.encl_base[31:0] = merge(s_reg.encl_base[31:0], s_reg.w_d, s_reg.w_s);
                ibt_pkg::REG_ENCL_BASE_HI: s_next.encl_base[47:32] =
                    16'(merge({16'h0000, s_reg.encl_base[47:32]}, s_reg.w_d, s_reg.w_s));
                ibt_pkg::REG_STATUS: s_next.b_r = 2'h0;
                default: s_next.b_r = 2'h2;
            endcase
        end

        // AXI4-Lite read channel
        if (s_reg.r_v && s_axi_rready) begin
            s_next.r_v = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_next.r_v = 1'b1;
            s_next.r_r = 2'h0;
            case (s_axi_araddr)
                ibt_pkg::REG_USER_CTL: rd = {27'h0000000, s_reg.user_ctl};
                ibt_pkg::REG_SUPV_CTL: rd = {27'h0000000, s_reg.supv_ctl};
                ibt_pkg::REG_MAP_BASE_LO: rd = s_reg.map_base[31:0];
                ibt_pkg::REG_MAP_BASE_HI: rd = {16'h0000, s_reg.map_base[47:32]};
                ibt_pkg::REG_ENCL_BASE_LO: rd = s_reg.encl_base[31:0];
                ibt_pkg::REG_ENCL_BASE_HI: rd = {16'h0000, s_reg.encl_base[47:32]};
                ibt_pkg::REG_STATUS: rd = {24'h000000, s_reg.load_cnt, s_reg.spec_cnt};
                default: begin
                    rd = 32'h00000000;
                    s_next.r_r = 2'h2;
                end
            endcase
            s_next.r_d = rd;
        end
    end

    // ------------------------------------------------------------
    // register stage
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
            s_reg.user_ctl <= ibt_pkg::CTL_RESET;
            s_reg.supv_ctl <= ibt_pkg::CTL_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // retire stalls during the map lookup so the restart sees no event window
    assign ins_ready = (s_reg.st == ibt_pkg::IBT_ST_RUN);
    assign ev_code = s_reg.ev;
    assign ev_valid = s_reg.ev_v;
    assign restart_no_window = s_reg.restart;
    // budget: fewer than 8 instructions and at most 5 loads past a missing marker
    assign spec_stall = (s_reg.spec_cnt >= ibt_pkg::SPEC_MAX_INSTR) ||
        (spec_is_load && s_reg.load_cnt >= ibt_pkg::SPEC_MAX_LOADS);
    assign mem_addr = s_reg.mem_addr;
    assign mem_req = s_reg.mem_req;
    // one write and one read outstanding; channels accepted independently
    assign s_axi_awready = !s_reg.aw_v;
    assign s_axi_wready = !s_reg.w_v;
    assign s_axi_bvalid = s_reg.b_v;
    assign s_axi_bresp = s_reg.b_r;
    assign s_axi_arready = !s_reg.r_v;
    assign s_axi_rvalid = s_reg.r_v;
    assign s_axi_rdata = s_reg.r_d;
    assign s_axi_rresp = s_reg.r_r;
endmodule

// ---- sim/ibt_check_assertions.sv ----
// ibt_check_assertions: concurrent checks on the ports of ibt_check.
// assumes one clock domain and ibt_pkg compiled first.
`timescale 1ns/1ps
module ibt_check_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // retire side
    input wire ibt_pkg::ibt_instr_t ins,
    input wire logic ins_ready,
    input wire ibt_pkg::ibt_event_t ev_code,
    input wire logic ev_valid,
    input wire logic restart_no_window,
    // map read side
    input wire logic [47:0] mem_addr,
    input wire logic mem_req,
    input wire logic mem_ack,
    input wire logic [7:0] mem_data,
    input wire logic mem_fault
);
    // ----
    // helper state
    // ----
    logic tk;
    logic [2:0] sel_q;
    logic encl_q;
    assign tk = ins.valid && ins_ready;
    // retire stalls during lookup, so it serves the last taken one
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sel_q <= 3'h0;
            encl_q <= 1'b0;
        end else if (tk) begin
            sel_q <= ins.linear_instruction_pointer[14:12];
            encl_q <= ins.enclave;
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_bp_first;
        tk && ins.is_bp1 && !ins.dbg_trap && !ins.code_bp && !(ins.enclave && !ins.enclave_opt_in)
            |=> ev_valid && ev_code == ibt_pkg::IBT_EV_BP;
    endproperty
    a_bp_first: assert property (p_bp_first) else $error("breakpoint trap not delivered");
    property p_dbg_first;
        tk && ins.dbg_trap |=> ev_valid && ev_code == ibt_pkg::IBT_EV_DBG_TRAP;
    endproperty
    a_dbg_first: assert property (p_dbg_first) else $error("debug trap lost priority");
    property p_code_bp;
        tk && ins.code_bp && !ins.dbg_trap |=> ev_valid && ev_code == ibt_pkg::IBT_EV_CODE_BP;
    endproperty
    a_code_bp: assert property (p_code_bp) else $error("code breakpoint lost priority");
    property p_encl_out;
        tk && ins.is_bp1 && ins.enclave && !ins.enclave_opt_in && !ins.dbg_trap && !ins.code_bp
            |=> ev_valid && (ev_code == ibt_pkg::IBT_EV_UD || ev_code == ibt_pkg::IBT_EV_CP);
    endproperty
    a_encl_out: assert property (p_encl_out) else $error("opt-out enclave breakpoint wrong");
    property p_map_clear;
        mem_ack && !mem_fault && !encl_q && !mem_data[sel_q]
            |=> ev_valid && ev_code == ibt_pkg::IBT_EV_CP && !restart_no_window;
    endproperty
    a_map_clear: assert property (p_map_clear) else $error("clear map bit did not fault");
    property p_map_set;
        mem_ack && !mem_fault && !encl_q && mem_data[sel_q] |=> restart_no_window && !ev_valid;
    endproperty
    a_map_set: assert property (p_map_set) else $error("legacy page not restarted");
    property p_lookup_fault;
        mem_ack && mem_fault |=> ev_valid && ev_code == ibt_pkg::IBT_EV_LOOKUP_FAULT && !restart_no_window;
    endproperty
    a_lookup_fault: assert property (p_lookup_fault) else $error("lookup fault not delivered");
    property p_req_hold;
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("map read dropped or moved");
    property p_lookup_blocks;
        mem_req |-> !ins_ready;
    endproperty
    a_lookup_blocks: assert property (p_lookup_blocks) else $error("retire accepted during lookup");
    c_restart: cover property (restart_no_window);
    c_cp: cover property (ev_valid && ev_code == ibt_pkg::IBT_EV_CP);
    c_fault: cover property (mem_ack && mem_fault);
endmodule

bind ibt_check ibt_check_assertions i_chk (.*);

// ---- sim/ibt_map_model.sv ----
// ibt_map_model: memory holding the legacy page map, one byte per request.
// assumes mem_req holds until mem_ack; bench sets latency and fault.
`timescale 1ns/1ps
module ibt_map_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // map read port
    input wire logic [47:0] mem_addr,
    input wire logic mem_req,
    output logic mem_ack,
    output logic [7:0] mem_data,
    output logic mem_fault,
    // behaviour controls
    input wire logic [3:0] lat,
    input wire logic fault_en
);
    logic [7:0] map_mem [256];
    logic [3:0] cnt;
    // data toggles between answers so a stale byte never looks valid
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 4'h0;
            mem_ack <= 1'b0;
            mem_data <= 8'hA5;
            mem_fault <= 1'b0;
        end else begin
            mem_ack <= 1'b0;
            mem_fault <= 1'b0;
            mem_data <= ~mem_data;
            if (mem_req && !mem_ack) begin
                cnt <= (cnt == lat) ? 4'h0 : cnt + 4'h1;
                if (cnt == lat) begin
                    mem_ack <= 1'b1;
                    mem_data <= map_mem[mem_addr[7:0]];
                    mem_fault <= fault_en;
                end
            end
        end
    end
endmodule

// ---- sim/ibt_check_test.sv ----
// ibt_check_test: directed and random retire traffic with register access.
// assumes ibt_map_model answers map reads; map base high word left zero.
`timescale 1ns/1ps
module ibt_check_test;
    logic clk, rstn, ins_ready, ev_valid, restart_no_window, spec_issue, spec_is_load, next_is_marker, spec_stall;
    ibt_pkg::ibt_instr_t ins, i;
    ibt_pkg::ibt_event_t ev_code;
    logic [47:0] mem_addr, ea;
    logic mem_req, mem_ack, mem_fault, fault_en, sd;
    logic [7:0] mem_data, s_axi_awaddr, s_axi_araddr;
    logic [3:0] lat;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, base;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    integer seed, n_errors, samples_checked, n;
    ibt_check i_dut (.*, .s_axi_wstrb(4'hF));
    ibt_map_model i_map (.*);
    // ----
    // helpers
    // ----
    task check(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // handshakes judged at the negedge before the taking edge
    task wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w, b;
        b = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b) begin
            @(negedge clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        logic ar, v;
        v = 1'b0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!v) begin
            @(negedge clk);
            ar = s_axi_arvalid && s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
    task go(input ibt_pkg::ibt_instr_t x);
        logic rdy;
        rdy = 1'b0;
        @(posedge clk);
        ins <= x;
        while (!rdy) begin
            @(negedge clk);
            rdy = ins_ready;
            @(posedge clk);
        end
        ins.valid <= 1'b0;
    endtask
    task ev_chk(input logic v, input ibt_pkg::ibt_event_t c);
        @(negedge clk);
        check(ev_valid, v);
        if (v) check(ev_code, c);
    endtask
    function automatic ibt_pkg::ibt_instr_t mk(input logic ind, input logic mark, input logic bp);
        ibt_pkg::ibt_instr_t x;
        x = '0;
        x.valid = 1'b1;
        x.pl = 2'h3;
        x.is_indirect = ind;
        x.is_marker = mark;
        x.is_bp1 = bp;
        x.linear_instruction_pointer = 48'({$random(seed), $random(seed)});
        x.long_mode_active = x.linear_instruction_pointer[47];
        x.cs_64 = x.linear_instruction_pointer[46];
        return x;
    endfunction
    function automatic logic [47:0] exp_addr(input ibt_pkg::ibt_instr_t x);
        return (x.long_mode_active && x.cs_64) ? base + {15'h0, x.linear_instruction_pointer[47:15]} : base + {31'h0, x.linear_instruction_pointer[31:15]};
    endfunction
    // ----
    // clock, watchdog and main sequence
    // ----
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task rdu;
        rd(ibt_pkg::REG_USER_CTL);
    endtask
    // run needs under 20000 cycles
    initial begin
        #200000;
        n_errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        end_of_test;
    end
    initial begin
        {seed, n_errors, samples_checked} = {32'h2060C876, 64'h0};
        {rstn, spec_issue, spec_is_load, next_is_marker, fault_en, lat, ins} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        for (n = 0; n < 256; n++) i_map.map_mem[n] = 8'($random(seed));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        rdu;
        check(d, 32'h0);
        rd(8'h1C);
        check({r, d}, {2'h2, 32'h0});
        base = $random(seed);
        wr(ibt_pkg::REG_MAP_BASE_LO, base);
        rd(ibt_pkg::REG_MAP_BASE_LO);
        check(d, base);
        wr(ibt_pkg::REG_USER_CTL, 32'h1);
        i = mk(1, 0, 0);
        i.no_track_prefix = 1'b1;
        go(i);
        rdu;
        check(d[3], 1'b0);
        go(mk(1, 0, 0));
        rdu;
        check(d[3], 1'b1);
        i = mk(0, 0, 0);
        {i.nm, i.ud, i.gd} = 3'h7;
        go(i);
        ev_chk(1'b1, ibt_pkg::IBT_EV_CP);
        i.dbg_trap = 1'b1;
        go(i);
        ev_chk(1'b1, ibt_pkg::IBT_EV_DBG_TRAP);
        i.code_bp = 1'b1;
        i.dbg_trap = 1'b0;
        go(i);
        ev_chk(1'b1, ibt_pkg::IBT_EV_CODE_BP);
        go(mk(0, 0, 1));
        ev_chk(1'b1, ibt_pkg::IBT_EV_BP);
        rdu;
        check(d[3], 1'b1);
        repeat (10) begin
            @(posedge clk);
            spec_issue <= 1'b1;
            spec_is_load <= 1'($random(seed));
        end
        @(negedge clk);
        check(spec_stall, 1'b1);
        @(posedge clk);
        spec_issue <= 1'b0;
        i = mk(0, 0, 0);
        i.is_transaction_begin_instr_abort = 1'b1;
        go(i);
        ev_chk(1'b0, ibt_pkg::IBT_EV_NONE);
        rdu;
        check(d[4:3], 2'h0);
        i.is_transaction_begin_instr_abort = 1'b0;
        i.is_interrupt_return_instr_dbg = 1'b1;
        go(i);
        rdu;
        check(d[3], 1'b1);
        wr(ibt_pkg::REG_USER_CTL, 32'h0);
        i = mk(0, 0, 1);
        i.enclave = 1'b1;
        go(i);
        ev_chk(1'b1, ibt_pkg::IBT_EV_UD);
        i.enclave_opt_in = 1'b1;
        go(i);
        ev_chk(1'b1, ibt_pkg::IBT_EV_BP);
        repeat (24) begin
            sd = 1'($random(seed));
            wr(ibt_pkg::REG_USER_CTL, {29'h0, sd, 2'h3});
            lat <= 4'($random(seed));
            fault_en <= ($random(seed) % 4 == 0);
            go(mk(1, 0, 0));
            ev_chk(1'b0, ibt_pkg::IBT_EV_NONE);
            i = mk(0, 0, 0);
            ea = exp_addr(i);
            go(i);
            for (n = 0; n < 50 && !mem_req; n++) @(negedge clk);
            check(mem_addr, ea);
            for (n = 0; n < 50 && !ev_valid && !restart_no_window; n++) @(negedge clk);
            if (fault_en) begin
                check(ev_code, ibt_pkg::IBT_EV_LOOKUP_FAULT);
                rdu;
                check(d[3], 1'b1);
            end else if (i_map.map_mem[ea[7:0]][i.linear_instruction_pointer[14:12]]) begin
                check(restart_no_window, 1'b1);
                rdu;
                check(d[4:3], {~sd, 1'b0});
                go(mk(1, 0, 0));
                rdu;
                check(d[3], sd);
                go(mk(0, 1, 0));
                rdu;
                check(d[4:3], 2'h0);
            end else begin
                check({ev_valid, ev_code}, {1'b1, ibt_pkg::IBT_EV_CP});
            end
        end
        end_of_test;
    end
endmodule
